// ---- design/tsfd_decoder.sv ----
// function code decoder for the magnetic tape synchronizer
// Overview of operation
// - A write code starts forward motion and each host output word is sent to the write circuits with a sprocket.
// - A write code with no output word lets six inches of tape pass, then writes the file mark and a check character.
// - A reverse code followed by an input request runs reverse and stops at the next record gap.
// - A reverse code with no input request runs to the file mark gap only and frees the decoder at once.
// - A read code followed by an input request runs forward and passes tape data to the host.
// - A read code with no input request searches forward for the file mark gap and frees the decoder at once.
// - A status code opens the status path, whose word shows busy during rewind or search.
// - The rewind-unload code commands fast reverse off the reel and frees the decoder at once.
// - The rewind-load code commands fast reverse to the load point and frees the decoder at once.
// - The handler whose switch equals the lowest code digit is selected.
// - A leading 2 sets the word assembly flag, a leading 1 clears it, and other leading digits leave it unchanged.
// - Leading digits 21 pick high density and 11 pick low density.
// - The lockout flag blocks selection until 25 us after the end-of-record circuit is enabled.
`timescale 1ns/1ns
`default_nettype none
module tsfd_decoder #(
	parameter int NUM_UNITS = 8,
	parameter int DECIDE_CYC = tsfd_pkg::DECIDE_CYC,
	parameter int FM_GAP_CYC = tsfd_pkg::FM_GAP_CYC
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [11:0] func_code,
	input wire logic func_valid,
	output logic func_ready,
	input wire logic [11:0] out_word,
	input wire logic out_valid,
	output logic out_ready,
	input wire logic in_req,
	output logic [11:0] in_data,
	output logic in_valid,
	output logic status_path_en,
	input wire logic [NUM_UNITS*3-1:0] unit_switch,
	output logic [NUM_UNITS-1:0] unit_sel,
	output logic fwd_motion,
	output logic rev_motion,
	output logic fast_rewind,
	output logic unload_cmd,
	output logic stop_record_gap,
	output logic file_mark_gap_only,
	output logic write_enable,
	input wire logic write_ready,
	output logic sprocket,
	output logic [11:0] write_data,
	input wire logic [11:0] tape_data,
	input wire logic tape_valid,
	input wire logic eor_sensed,
	input wire logic motion_done,
	output logic word_assembly_flag,
	output logic density_high,
	output logic function_lockout_flag
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0, ST_DECIDE = 4'h1, ST_WRITE = 4'h3, ST_READ = 4'h2,
		ST_BACK = 4'h6, ST_EOR = 4'h7, ST_FMGAP = 4'h5, ST_FMCHR = 4'h4,
		ST_FMCHK = 4'hC, ST_STATUS = 4'hD
	} tsfd_state_t;

	tsfd_state_t state_r, state_nxt;
	logic [2:0] op_r, op_nxt, unit_r, unit_nxt;
	logic [tsfd_pkg::TIMER_W-1:0] timer_r, timer_nxt;
	logic lock_r, lock_nxt, asm_r, asm_nxt, dens_r, dens_nxt, busy_r, busy_nxt;
	logic fwd_r, fwd_nxt, rev_r, rev_nxt, fast_r, fast_nxt, unl_r, unl_nxt;
	logic gap_r, gap_nxt, fmo_r, fmo_nxt, wen_r, wen_nxt, spr_r, spr_nxt;
	logic sel_r, sel_nxt, ival_r, ival_nxt, stat_r, stat_nxt;
	logic [11:0] wdat_r, wdat_nxt, idat_r, idat_nxt;
	logic accept, fifo_valid, fifo_pop, fifo_in_ready, timer_zero;
	logic [11:0] fifo_data;
	logic [2:0] lead, op_in;
	logic [11:0] status_word;

	assign func_ready = (state_r == ST_IDLE) && !lock_r;
	assign accept = func_valid && func_ready;
	assign lead = func_code[tsfd_pkg::LEAD_POS +: 3];
	assign op_in = func_code[tsfd_pkg::OP_POS +: 3];
	assign timer_zero = timer_r == '0;
	assign out_ready = fifo_in_ready && (state_r == ST_DECIDE || state_r == ST_WRITE);
	assign fifo_pop = (state_r == ST_WRITE) && write_ready;

	always_comb begin
		status_word = '0;
		status_word[tsfd_pkg::STAT_BUSY] = busy_r;
		status_word[tsfd_pkg::STAT_ASSEMBLY] = asm_r;
		status_word[tsfd_pkg::STAT_DENSITY] = dens_r;
	end

	tsfd_fifo #(.WIDTH(tsfd_pkg::WORD_W), .DEPTH(tsfd_pkg::FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(out_valid && out_ready),
		.in_ready(fifo_in_ready),
		.in_data(out_word),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
			assign unit_sel[gi] = sel_r && (unit_switch[gi*3 +: 3] == unit_r);
		end
	endgenerate

	always_comb begin
		state_nxt = state_r;
		op_nxt = op_r;
		unit_nxt = unit_r;
		timer_nxt = timer_zero ? timer_r : timer_r - 1'b1;
		lock_nxt = lock_r;
		asm_nxt = asm_r;
		dens_nxt = dens_r;
		busy_nxt = motion_done ? 1'b0 : busy_r;
		fwd_nxt = fwd_r;
		rev_nxt = rev_r;
		fast_nxt = fast_r;
		unl_nxt = unl_r;
		gap_nxt = gap_r;
		fmo_nxt = fmo_r;
		wen_nxt = wen_r;
		spr_nxt = 1'b0;
		sel_nxt = sel_r;
		ival_nxt = 1'b0;
		stat_nxt = stat_r;
		wdat_nxt = wdat_r;
		idat_nxt = idat_r;
		case (state_r)
			ST_IDLE: begin
				if (accept) begin
					op_nxt = op_in;
					unit_nxt = func_code[tsfd_pkg::UNIT_POS +: 3];
					sel_nxt = 1'b1;
					if (lead == tsfd_pkg::LEAD_WORD) begin
						asm_nxt = 1'b1;
					end else if (lead == tsfd_pkg::LEAD_CHAR) begin
						asm_nxt = 1'b0;
					end
					if (op_in != tsfd_pkg::OP_DENSITY && op_in != tsfd_pkg::OP_STATUS) begin
						fwd_nxt = 1'b0;
						rev_nxt = 1'b0;
						fast_nxt = 1'b0;
						unl_nxt = 1'b0;
						gap_nxt = 1'b0;
						fmo_nxt = 1'b0;
						wen_nxt = 1'b0;
					end
					if (op_in == tsfd_pkg::OP_DENSITY) begin
						if (func_code[tsfd_pkg::MODE_POS +: 3] == tsfd_pkg::MODE_DENS) begin
							dens_nxt = lead == tsfd_pkg::LEAD_WORD;
						end
					end else if (op_in == tsfd_pkg::OP_WRITE || op_in == tsfd_pkg::OP_READ) begin
						fwd_nxt = 1'b1;
						wen_nxt = op_in == tsfd_pkg::OP_WRITE;
						lock_nxt = 1'b1;
						timer_nxt = tsfd_pkg::TIMER_W'(DECIDE_CYC);
						state_nxt = ST_DECIDE;
					end else if (op_in == tsfd_pkg::OP_REVERSE) begin
						rev_nxt = 1'b1;
						lock_nxt = 1'b1;
						timer_nxt = tsfd_pkg::TIMER_W'(DECIDE_CYC);
						state_nxt = ST_DECIDE;
					end else if (op_in == tsfd_pkg::OP_STATUS) begin
						stat_nxt = 1'b1;
						state_nxt = ST_STATUS;
					end else if (op_in == tsfd_pkg::OP_UNLOAD || op_in == tsfd_pkg::OP_LOAD) begin
						rev_nxt = 1'b1;
						fast_nxt = 1'b1;
						unl_nxt = op_in == tsfd_pkg::OP_UNLOAD;
						busy_nxt = 1'b1;
					end
				end
			end
			ST_DECIDE: begin
				if (op_r == tsfd_pkg::OP_WRITE && fifo_valid) begin
					state_nxt = ST_WRITE;
				end else if (op_r == tsfd_pkg::OP_REVERSE && in_req) begin
					gap_nxt = 1'b1;
					state_nxt = ST_BACK;
				end else if (op_r == tsfd_pkg::OP_READ && in_req) begin
					state_nxt = ST_READ;
				end else if (timer_zero) begin
					if (op_r == tsfd_pkg::OP_WRITE) begin
						timer_nxt = tsfd_pkg::TIMER_W'(FM_GAP_CYC);
						state_nxt = ST_FMGAP;
					end else begin
						fmo_nxt = 1'b1;
						busy_nxt = 1'b1;
						lock_nxt = 1'b0;
						sel_nxt = 1'b0;
						state_nxt = ST_IDLE;
					end
				end
			end
			ST_WRITE: begin
				if (fifo_valid && write_ready) begin
					spr_nxt = 1'b1;
					wdat_nxt = fifo_data;
				end
				if (eor_sensed) begin
					fwd_nxt = 1'b0;
					wen_nxt = 1'b0;
					timer_nxt = tsfd_pkg::TIMER_W'(tsfd_pkg::LOCKOUT_CYC);
					state_nxt = ST_EOR;
				end
			end
			ST_FMGAP: begin
				if (timer_zero) begin
					state_nxt = ST_FMCHR;
				end
			end
			ST_FMCHR: begin
				spr_nxt = 1'b1;
				wdat_nxt = tsfd_pkg::FILE_MARK_CHAR;
				state_nxt = ST_FMCHK;
			end
			ST_FMCHK: begin
				spr_nxt = 1'b1;
				wdat_nxt = tsfd_pkg::CHECK_CHAR;
				fwd_nxt = 1'b0;
				wen_nxt = 1'b0;
				timer_nxt = tsfd_pkg::TIMER_W'(tsfd_pkg::LOCKOUT_CYC);
				state_nxt = ST_EOR;
			end
			ST_READ, ST_BACK: begin
				if (state_r == ST_READ && tape_valid) begin
					ival_nxt = 1'b1;
					idat_nxt = tape_data;
				end
				if (eor_sensed) begin
					fwd_nxt = 1'b0;
					rev_nxt = 1'b0;
					gap_nxt = 1'b0;
					timer_nxt = tsfd_pkg::TIMER_W'(tsfd_pkg::LOCKOUT_CYC);
					state_nxt = ST_EOR;
				end
			end
			ST_EOR: begin
				if (timer_zero) begin
					lock_nxt = 1'b0;
					sel_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end
			end
			ST_STATUS: begin
				if (in_req) begin
					ival_nxt = 1'b1;
					idat_nxt = status_word;
					stat_nxt = 1'b0;
					sel_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state_r <= ST_IDLE;
			op_r <= '0;
			unit_r <= '0;
			timer_r <= '0;
			{lock_r, asm_r, dens_r, busy_r, fwd_r, rev_r, fast_r, unl_r} <= '0;
			{gap_r, fmo_r, wen_r, spr_r, sel_r, ival_r, stat_r} <= '0;
			wdat_r <= '0;
			idat_r <= '0;
		end else begin
			state_r <= state_nxt;
			op_r <= op_nxt;
			unit_r <= unit_nxt;
			timer_r <= timer_nxt;
			{lock_r, asm_r, dens_r, busy_r} <= {lock_nxt, asm_nxt, dens_nxt, busy_nxt};
			{fwd_r, rev_r, fast_r, unl_r} <= {fwd_nxt, rev_nxt, fast_nxt, unl_nxt};
			{gap_r, fmo_r, wen_r, spr_r} <= {gap_nxt, fmo_nxt, wen_nxt, spr_nxt};
			{sel_r, ival_r, stat_r} <= {sel_nxt, ival_nxt, stat_nxt};
			wdat_r <= wdat_nxt;
			idat_r <= idat_nxt;
		end
	end

	assign in_data = idat_r;
	assign in_valid = ival_r;
	assign status_path_en = stat_r;
	assign fwd_motion = fwd_r;
	assign rev_motion = rev_r;
	assign fast_rewind = fast_r;
	assign unload_cmd = unl_r;
	assign stop_record_gap = gap_r;
	assign file_mark_gap_only = fmo_r;
	assign write_enable = wen_r;
	assign sprocket = spr_r;
	assign write_data = wdat_r;
	assign word_assembly_flag = asm_r;
	assign density_high = dens_r;
	assign function_lockout_flag = lock_r;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	a_sprocket_word: assert property (fifo_pop && fifo_valid |=> spr_r && wen_r && wdat_r == $past(fifo_data))
		else $error("write word not passed with sprocket");
	a_file_mark_pair: assert property (state_r == ST_FMCHR |=> spr_r && wdat_r == tsfd_pkg::FILE_MARK_CHAR
		##1 spr_r && wdat_r == tsfd_pkg::CHECK_CHAR)
		else $error("file mark and check character not written");
	a_backspace_gap: assert property (state_r == ST_DECIDE && op_r == tsfd_pkg::OP_REVERSE && in_req
		|=> rev_r && gap_r && state_r == ST_BACK)
		else $error("backspace did not arm record gap stop");
	a_reverse_search: assert property (state_r == ST_DECIDE && op_r == tsfd_pkg::OP_REVERSE
		&& timer_zero && !in_req |=> rev_r && fmo_r && func_ready)
		else $error("reverse file mark search not released");
	a_read_pass: assert property (state_r == ST_READ && tape_valid |=> in_valid && in_data == $past(tape_data))
		else $error("read data not passed to host");
	a_fwd_search: assert property (state_r == ST_DECIDE && op_r == tsfd_pkg::OP_READ
		&& timer_zero && !in_req |=> fwd_r && fmo_r && func_ready)
		else $error("forward search not released");
	a_status_busy: assert property (state_r == ST_STATUS && in_req && !motion_done
		|=> in_valid && in_data[tsfd_pkg::STAT_BUSY] == $past(busy_r))
		else $error("status busy bit wrong");
	a_unload_cmd: assert property (accept && op_in == tsfd_pkg::OP_UNLOAD
		|=> rev_r && fast_r && unl_r && busy_r && func_ready)
		else $error("rewind unload not commanded");
	a_load_cmd: assert property (accept && op_in == tsfd_pkg::OP_LOAD |=> rev_r && fast_r && !unl_r && func_ready)
		else $error("rewind load not commanded");
	a_unit_match: assert property (sel_r && unit_switch[2:0] == unit_r |-> unit_sel[0])
		else $error("handler with matching switch not selected");
	a_assembly_set: assert property (accept && lead == tsfd_pkg::LEAD_WORD |=> word_assembly_flag)
		else $error("word assembly flag not set");
	a_density_high: assert property (accept && op_in == tsfd_pkg::OP_DENSITY
		&& func_code[tsfd_pkg::MODE_POS +: 3] == tsfd_pkg::MODE_DENS
		|=> density_high == ($past(lead) == tsfd_pkg::LEAD_WORD))
		else $error("density not taken from code");
	a_lockout_hold: assert property (state_r != ST_IDLE && state_r != ST_STATUS |-> lock_r && !func_ready)
		else $error("selection taken during lockout");
	a_lockout_release: assert property (state_r == ST_EOR && timer_r == 1 |=> lock_r ##1 !lock_r && func_ready)
		else $error("lockout not cleared after end of record delay");

	c_write: cover property (state_r == ST_WRITE ##1 state_r == ST_EOR);
	c_file_mark: cover property (state_r == ST_FMCHK);
	c_read: cover property (state_r == ST_READ && tape_valid);
	c_status: cover property (state_r == ST_STATUS && in_req);
endmodule
`default_nettype wire

// ---- design/tsfd_fifo.sv ----
// output word fifo between host and write circuits
`timescale 1ns/1ns
`default_nettype none
module tsfd_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
	logic push, pop;

	assign in_ready = (wptr_r - rptr_r) != (AW+1)'(DEPTH);
	assign out_valid = wptr_r != rptr_r;
	assign out_data = mem[rptr_r[AW-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wptr_nxt = push ? wptr_r + 1'b1 : wptr_r;
		rptr_nxt = pop ? rptr_r + 1'b1 : rptr_r;
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			wptr_r <= wptr_nxt;
			rptr_r <= rptr_nxt;
		end
		if (push) begin
			mem[wptr_r[AW-1:0]] <= in_data;
		end
	end
endmodule
`default_nettype wire

// ---- design/tsfd_pkg.sv ----
// constants for the tape synchronizer function decoder
package tsfd_pkg;
	localparam int CLK_MHZ = 50;
	// function code digits (octal, four digits)
	localparam int LEAD_POS = 9;
	localparam int MODE_POS = 6;
	localparam int OP_POS = 3;
	localparam int UNIT_POS = 0;
	localparam logic [2:0] LEAD_WORD = 3'h2;
	localparam logic [2:0] LEAD_CHAR = 3'h1;
	localparam logic [2:0] MODE_DENS = 3'h1;
	localparam logic [2:0] OP_DENSITY = 3'h0;
	localparam logic [2:0] OP_WRITE = 3'h1;
	localparam logic [2:0] OP_REVERSE = 3'h2;
	localparam logic [2:0] OP_READ = 3'h3;
	localparam logic [2:0] OP_STATUS = 3'h4;
	localparam logic [2:0] OP_UNLOAD = 3'h5;
	localparam logic [2:0] OP_LOAD = 3'h6;
	// tape characters
	localparam logic [11:0] FILE_MARK_CHAR = 12'h00F;
	localparam logic [11:0] CHECK_CHAR = 12'h00F;
	// status word fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_ASSEMBLY = 1;
	localparam int STAT_DENSITY = 2;
	// times and cycle counts
	localparam int LOCKOUT_US = 25;
	localparam int LOCKOUT_CYC = LOCKOUT_US * CLK_MHZ;
	localparam int DECIDE_US = 3500;
	localparam int DECIDE_CYC = DECIDE_US * CLK_MHZ;
	localparam int FM_GAP_US = 40000;
	localparam int FM_GAP_CYC = FM_GAP_US * CLK_MHZ;
	localparam int FIFO_DEPTH = 8;
	localparam int WORD_W = 12;
	localparam int TIMER_W = 24;
endpackage

// ---- verification/tb_top.sv ----
// self-checking bench for the function decoder
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clock;
	logic reset;
	logic write_ready;
	logic [11:0] tape_data;
	logic tape_valid;
	logic eor_sensed;
	logic motion_done;
	logic [23:0] unit_switch;
	logic [11:0] func_code, out_word, in_data, write_data;
	logic func_valid, func_ready, out_valid, out_ready, in_req, in_valid, status_path_en;
	logic [7:0] unit_sel;
	logic fwd_motion, rev_motion, fast_rewind, unload_cmd, stop_record_gap, file_mark_gap_only;
	logic write_enable, sprocket, word_assembly_flag, density_high, function_lockout_flag;
	logic [11:0] wq[$];
	logic [11:0] iq[$];
	int error_cnt = 0;
	int total_checks = 0;
	int n;
	always #10 clock = ~clock;
	tsfd_host host (.clock(clock), .func_ready(func_ready), .out_ready(out_ready), .func_code(func_code),
		.func_valid(func_valid), .out_word(out_word), .out_valid(out_valid), .in_req(in_req));
	tsfd_decoder #(.DECIDE_CYC(20), .FM_GAP_CYC(10)) dut (.clock(clock), .reset(reset),
		.func_code(func_code), .func_valid(func_valid), .func_ready(func_ready), .out_word(out_word),
		.out_valid(out_valid), .out_ready(out_ready), .in_req(in_req), .in_data(in_data), .in_valid(in_valid),
		.status_path_en(status_path_en), .unit_switch(unit_switch), .unit_sel(unit_sel),
		.fwd_motion(fwd_motion), .rev_motion(rev_motion), .fast_rewind(fast_rewind), .unload_cmd(unload_cmd),
		.stop_record_gap(stop_record_gap), .file_mark_gap_only(file_mark_gap_only),
		.write_enable(write_enable), .write_ready(write_ready), .sprocket(sprocket), .write_data(write_data),
		.tape_data(tape_data), .tape_valid(tape_valid), .eor_sensed(eor_sensed), .motion_done(motion_done),
		.word_assembly_flag(word_assembly_flag), .density_high(density_high),
		.function_lockout_flag(function_lockout_flag));
	// capture pulses where outputs are settled
	always @(negedge clock) begin
		if (sprocket === 1'h1) wq.push_back(write_data);
		if (in_valid === 1'h1) iq.push_back(in_data);
	end
	task chk(input string name, input logic [11:0] seen, input logic [11:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task wrap_up();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task wait_ready();
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (func_ready !== 1'h1 && n < 4000);
		chk("ready_wait", func_ready, 1'h1);
	endtask
	// end of record pulse, then cycles until selectable again
	task eor();
		@(posedge clock);
		#1;
		eor_sensed = 1'h1;
		@(posedge clock);
		#1;
		eor_sensed = 1'h0;
		wait_ready();
	endtask
	task t_density();
		host.code(12'h441);
		@(negedge clock);
		chk("dens_hi", density_high, 1'h1);
		chk("assy_on", word_assembly_flag, 1'h1);
		host.code(12'h241);
		@(negedge clock);
		chk("dens_lo", density_high, 1'h0);
		chk("assy_off", word_assembly_flag, 1'h0);
		host.code(12'h441);
	endtask
	task t_rewind();
		host.code(12'h471);
		@(negedge clock);
		chk("sel_load", unit_sel, 8'h40);
		chk("rev_load", {rev_motion, fast_rewind, unload_cmd}, 3'h6);
		chk("free_load", func_ready, 1'h1);
		@(posedge clock);
		#1;
		unit_switch = 24'hFAC642;
		host.code(12'h46A);
		@(negedge clock);
		chk("sel_unl", unit_sel, 8'h01);
		chk("rev_unl", {rev_motion, fast_rewind, unload_cmd}, 3'h7);
		chk("free_unl", func_ready, 1'h1);
	endtask
	task t_status(input logic [11:0] exp);
		iq.delete();
		host.code(12'h461);
		@(negedge clock);
		chk("stat_path", status_path_en, 1'h1);
		host.inreq();
		repeat (2) @(negedge clock);
		chk("stat_cnt", iq.size(), 12'h001);
		if (iq.size() > 0) chk("stat_word", iq[0], exp);
	endtask
	task t_write();
		host.code(12'h449);
		@(negedge clock);
		chk("wr_motion", {fwd_motion, write_enable}, 2'h3);
		for (int i = 0; i < 8; i++) host.word(12'h100 + 12'(i));
		@(negedge clock);
		chk("fifo_full", out_ready, 1'h0);
		chk("stalled", wq.size(), 12'h000);
		@(posedge clock);
		#1;
		write_ready = 1'h1;
		repeat (12) @(negedge clock);
		chk("wr_cnt", wq.size(), 12'h008);
		for (int i = 0; i < 8 && i < wq.size(); i++) chk("wr_word", wq[i], 12'h100 + 12'(i));
		chk("lock_on", function_lockout_flag, 1'h1);
		eor();
		chk("lock_cyc", 12'(n), 12'h4E4);
		chk("wr_off", write_enable, 1'h0);
	endtask
	task t_fmark();
		wq.delete();
		host.code(12'h44A);
		wait_ready();
		chk("fm_cnt", wq.size(), 12'h002);
		if (wq.size() == 2) chk("fm_char", wq[0], 12'h00F);
		if (wq.size() == 2) chk("fm_check", wq[1], 12'h00F);
	endtask
	task t_back();
		host.code(12'h453);
		host.inreq();
		@(negedge clock);
		chk("bk_one", {rev_motion, stop_record_gap}, 2'h3);
		eor();
		host.code(12'h454);
		wait_ready();
		chk("bk_fm", {rev_motion, file_mark_gap_only}, 2'h3);
		chk("bk_free", n <= 25, 1'h1);
	endtask
	task t_read();
		iq.delete();
		host.code(12'h45D);
		host.inreq();
		@(posedge clock);
		#1;
		tape_data = 12'hA5C;
		tape_valid = 1'h1;
		@(posedge clock);
		#1;
		tape_valid = 1'h0;
		tape_data = 12'h5A3;
		repeat (2) @(negedge clock);
		chk("rd_fwd", fwd_motion, 1'h1);
		chk("rd_cnt", iq.size(), 12'h001);
		if (iq.size() > 0) chk("rd_data", iq[0], 12'hA5C);
		eor();
		host.code(12'h45E);
		wait_ready();
		chk("sr_fm", {fwd_motion, file_mark_gap_only}, 2'h3);
		chk("sr_free", n <= 25, 1'h1);
	endtask
	initial begin
		clock = 1'h0;
		reset = 1'h1;
		write_ready = 1'h0;
		tape_data = 12'h000;
		tape_valid = 1'h0;
		eor_sensed = 1'h0;
		motion_done = 1'h0;
		unit_switch = 24'h053977;
		repeat (16) @(posedge clock);
		#1;
		reset = 1'h0;
		t_density();
		t_rewind();
		t_status(12'h007);
		@(posedge clock);
		#1;
		motion_done = 1'h1;
		@(posedge clock);
		#1;
		motion_done = 1'h0;
		t_status(12'h006);
		t_write();
		t_fmark();
		t_back();
		t_read();
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge clock);
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire

// ---- verification/tsfd_host.sv ----
// host channel model: function codes, output words, input requests
`timescale 1ns/1ns
`default_nettype none
module tsfd_host (
	input wire logic clock,
	input wire logic func_ready,
	input wire logic out_ready,
	output logic [11:0] func_code,
	output logic func_valid,
	output logic [11:0] out_word,
	output logic out_valid,
	output logic in_req
);
	initial begin
		func_code = 12'h000;
		func_valid = 1'h0;
		out_word = 12'h000;
		out_valid = 1'h0;
		in_req = 1'h0;
	end
	// offer a code, hold until taken, then scramble the lines
	task code(input logic [11:0] c);
		@(posedge clock);
		#1;
		func_code = c;
		func_valid = 1'h1;
		do @(negedge clock); while (func_ready !== 1'h1);
		@(posedge clock);
		#1;
		func_valid = 1'h0;
		func_code = ~c;
	endtask
	// offer an output word, hold until taken
	task word(input logic [11:0] w);
		@(posedge clock);
		#1;
		out_word = w;
		out_valid = 1'h1;
		do @(negedge clock); while (out_ready !== 1'h1);
		@(posedge clock);
		#1;
		out_valid = 1'h0;
		out_word = ~w;
	endtask
	// input instruction, one cycle
	task inreq();
		@(posedge clock);
		#1;
		in_req = 1'h1;
		@(posedge clock);
		#1;
		in_req = 1'h0;
	endtask
endmodule
`default_nettype wire
